// ### design/ir_codec_params.svh
// Behaviour
// - Every word on the line is 14 bits and starts with two ones.
// - Then a check bit, a 5-bit address and 6 command bits follow.
// - One full word takes roughly 25 ms on the line.
// - User side handles one 12-bit value per word, fields not split.
// - Sustained throughput stays at or below about 500 bits per second.
// - Transmit pin high lights the LED, low turns it off.
// - After the leading ones, check bit goes first, then bits 10 down to 0.
// - A falling edge on the receive input starts decoding of a word.
// - Each decoded word lands in a received-word register read by software.
// - Unrecognised or malformed signal loads 0xffff into the received-word register.
// - Blocking receive waits for next word, returns it and also stores it.
// - Receive and transmit pins each chosen by port select and bit index.
`ifndef IR_CODEC_PARAMS_SVH
`define IR_CODEC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IR_ADDR_W               8
`define IR_OFF_SEND_WORD        8'h00
`define IR_OFF_RECEIVED_WORD    8'h04
`define IR_OFF_CONFIG           8'h08
`define IR_OFF_STATUS           8'h0c
`define IR_OFF_BLOCKING_RECEIVE 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IR_CFG_RATE_LSB         0
`define IR_CFG_RX_BIT_LSB       16
`define IR_CFG_RX_PORT_LSB      20
`define IR_CFG_TX_BIT_LSB       24
`define IR_CFG_TX_PORT_LSB      28
`define IR_ST_TX_BUSY           0
`define IR_ST_RX_BUSY           1
`define IR_ST_RX_NEW            2
`define IR_ST_LEVEL_LSB         4

// ----------------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------------
`define IR_INVALID_WORD         16'hffff
`define IR_PINS                 32
`define IR_CLK_HZ               25000000
`define IR_CLK_MHZ              25
`define IR_CARRIER_FREQUENCY_HZ 36000
`define IR_CARRIER_HALF_CYC     (`IR_CLK_HZ / (2 * `IR_CARRIER_FREQUENCY_HZ))
`define IR_HALF_BIT_US          889
`define IR_HALF_BIT_CYC         (`IR_HALF_BIT_US * `IR_CLK_MHZ)
`define IR_GAP_HALVES           8
`define IR_TX_LAST_HALF         5'h1b
`define IR_RX_LAST_SAMPLE       5'h1a
`define IR_RESP_OKAY            2'h0
`define IR_RESP_SLVERR          2'h2

`endif

// ### design/ir_codec_pkg.sv
package ir_codec_pkg;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_GAP  = 2'b10
   } tx_state_e;

   typedef enum logic {
      RX_IDLE = 1'b0,
      RX_RUN  = 1'b1
   } rx_state_e;

   typedef struct packed {
      logic            awready;
      logic            wready;
      logic            arready;
      logic            aw_got;
      logic [7:0]      aw_addr;
      logic            w_got;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [1:0]      rresp;
      logic [31:0]     rdata;
      logic            rd_wait;
      logic [11:0]     carrier_rate_setting;
      logic [1:0]      receive_port_select;
      logic [2:0]      receive_bit_index;
      logic [1:0]      transmit_port_select;
      logic [2:0]      transmit_bit_index;
      logic [15:0]     received_word;
      logic            rx_new;
      logic [31:0]     sync1;
      logic [31:0]     sync2;
      logic            rx_prev;
      rx_state_e       rx_st;
      logic [4:0]      rx_idx;
      logic [15:0]     rx_timer;
      logic            rx_fh;
      logic            rx_err;
      logic [12:0]     rx_bits;
      tx_state_e       tx_st;
      logic [13:0]     tx_frame;
      logic [4:0]      tx_half;
      logic [15:0]     tx_timer;
      logic            tx_mark;
      logic [11:0]     car_cnt;
      logic            car;
      logic            tx_line;
      logic [31:0]     tx_pins;
   } core_s;

endpackage

// ### design/word_buffer.sv
`timescale 1ns/1ps
module word_buffer #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 2,
   parameter int LW    = $clog2(DEPTH + 1),
   parameter int PW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [LW-1:0]         level
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [LW-1:0]               count;
      logic [PW-1:0]               rd;
   } buf_s;

   buf_s s_q;
   buf_s n;
   int   wr;
   logic push;
   logic pop;

   assign in_ready  = s_q.count != LW'(DEPTH);
   assign out_valid = s_q.count != '0;
   assign out_data  = s_q.mem[s_q.rd];
   assign level     = s_q.count;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      n  = s_q;
      wr = (int'(s_q.rd) + int'(s_q.count)) % DEPTH;
      if (push) begin
         n.mem[wr] = in_data;
      end
      if (pop) begin
         n.rd = PW'((int'(s_q.rd) + 1) % DEPTH);
      end
      n.count = LW'(int'(s_q.count) + int'(push) - int'(pop));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= n;
      end
   end

endmodule

// ### design/ir_remote_word_codec.sv
`timescale 1ns/1ps
`include "ir_codec_params.svh"
module ir_remote_word_codec #(
   parameter int HALF_BIT_CYCLES = `IR_HALF_BIT_CYC,
   parameter int GAP_HALVES      = `IR_GAP_HALVES,
   parameter int BUF_DEPTH       = 2
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [`IR_ADDR_W-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [`IR_ADDR_W-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   input  wire logic [`IR_PINS-1:0]   rx_pins,
   output logic [`IR_PINS-1:0]        tx_pins
);
   localparam int LW = $clog2(BUF_DEPTH + 1);
   localparam ir_codec_pkg::core_s RST = '{
      awready: 1'b1, wready: 1'b1, arready: 1'b1,
      carrier_rate_setting: 12'(`IR_CARRIER_HALF_CYC),
      received_word: `IR_INVALID_WORD,
      sync1: '1, sync2: '1, rx_prev: 1'b1, car: 1'b1,
      rx_st: ir_codec_pkg::RX_IDLE, tx_st: ir_codec_pkg::TX_IDLE,
      default: '0};

   ir_codec_pkg::core_s s_q;
   ir_codec_pkg::core_s n;
   logic                buf_in_valid;
   logic                buf_in_ready;
   logic                buf_out_valid;
   logic                buf_out_ready;
   logic [11:0]         buf_out_data;
   logic [LW-1:0]       buf_level;
   logic                lvl;
   logic                rx_done_c;
   logic                rx_bad_c;
   logic                wr_ok;
   logic [15:0]         word_c;
   logic [31:0]         cfg_img;
   logic [31:0]         st_img;
   logic [31:0]         wmask;

   assign awready = s_q.awready;
   assign wready  = s_q.wready;
   assign bvalid  = s_q.bvalid;
   assign bresp   = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid  = s_q.rvalid;
   assign rresp   = s_q.rresp;
   assign rdata   = s_q.rdata;
   assign tx_pins = s_q.tx_pins;

   // ----------------------------------------------------------------------
   // Send path buffer
   // ----------------------------------------------------------------------
   // Holds the next word while one is on the line; a full buffer stalls bvalid
   assign buf_in_valid  = s_q.aw_got && s_q.w_got && !s_q.bvalid
                          && s_q.aw_addr == `IR_OFF_SEND_WORD;
   assign buf_out_ready = s_q.tx_st == ir_codec_pkg::TX_IDLE;

   word_buffer #(
      .WIDTH (12),
      .DEPTH (BUF_DEPTH)
   ) u_send_buffer (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (s_q.w_data[11:0]),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data),
      .level     (buf_level)
   );

   // Register images
   always_comb begin
      cfg_img = '0;
      cfg_img[`IR_CFG_RATE_LSB +: 12]   = s_q.carrier_rate_setting;
      cfg_img[`IR_CFG_RX_BIT_LSB +: 3]  = s_q.receive_bit_index;
      cfg_img[`IR_CFG_RX_PORT_LSB +: 2] = s_q.receive_port_select;
      cfg_img[`IR_CFG_TX_BIT_LSB +: 3]  = s_q.transmit_bit_index;
      cfg_img[`IR_CFG_TX_PORT_LSB +: 2] = s_q.transmit_port_select;
      st_img = '0;
      st_img[`IR_ST_TX_BUSY]          = s_q.tx_st != ir_codec_pkg::TX_IDLE;
      st_img[`IR_ST_RX_BUSY]          = s_q.rx_st == ir_codec_pkg::RX_RUN;
      st_img[`IR_ST_RX_NEW]           = s_q.rx_new;
      st_img[`IR_ST_LEVEL_LSB +: 4]   = 4'(buf_level);
      wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}},
               {8{s_q.w_strb[0]}}};
   end

   // Selected receive pin, read only from the second sync stage
   assign lvl = s_q.sync2[{s_q.receive_port_select, s_q.receive_bit_index}];

   always_comb begin
      logic [31:0] merged;
      merged    = '0;
      n         = s_q;
      rx_done_c = 1'b0;
      rx_bad_c  = 1'b0;
      word_c    = `IR_INVALID_WORD;
      wr_ok     = 1'b0;

      // ----------------------------------------------------------------------
      // Receive decoder
      // ----------------------------------------------------------------------
      n.sync1   = rx_pins;
      n.sync2   = s_q.sync1;
      n.rx_prev = lvl;
      case (s_q.rx_st)
         ir_codec_pkg::RX_IDLE: begin
            if (s_q.rx_prev && !lvl) begin
               n.rx_st    = ir_codec_pkg::RX_RUN;
               n.rx_timer = 16'(HALF_BIT_CYCLES / 2 - 1);
               n.rx_idx   = '0;
               n.rx_err   = 1'b0;
            end
         end
         ir_codec_pkg::RX_RUN: begin
            if (s_q.rx_timer != '0) begin
               n.rx_timer = s_q.rx_timer - 16'h1;
            end else begin
               // Samples fall mid-half; low input is mark
               n.rx_timer = 16'(HALF_BIT_CYCLES - 1);
               n.rx_idx   = s_q.rx_idx + 5'h1;
               if (s_q.rx_idx == '0) begin
                  n.rx_err = lvl;
               end else if (s_q.rx_idx[0]) begin
                  n.rx_fh = !lvl;
               end else begin
                  n.rx_err  = s_q.rx_err | (s_q.rx_fh == !lvl);
                  n.rx_bits = {s_q.rx_bits[11:0], !lvl};
               end
               if (s_q.rx_idx == `IR_RX_LAST_SAMPLE) begin
                  // Second leading one must be present as well
                  n.rx_st   = ir_codec_pkg::RX_IDLE;
                  rx_done_c = 1'b1;
                  rx_bad_c  = n.rx_err | !n.rx_bits[12];
               end
            end
         end
         default: n.rx_st = ir_codec_pkg::RX_IDLE;
      endcase
      word_c = rx_bad_c ? `IR_INVALID_WORD : {4'h0, n.rx_bits[11:0]};

      // ----------------------------------------------------------------------
      // Transmit sequencer
      // ----------------------------------------------------------------------
      case (s_q.tx_st)
         ir_codec_pkg::TX_IDLE: begin
            if (buf_out_valid) begin
               n.tx_st    = ir_codec_pkg::TX_SEND;
               n.tx_frame = {2'b11, buf_out_data};
               n.tx_half  = '0;
               n.tx_timer = '0;
            end
         end
         ir_codec_pkg::TX_SEND: begin
            if (s_q.tx_timer == 16'(HALF_BIT_CYCLES - 1)) begin
               n.tx_timer = '0;
               if (s_q.tx_half == `IR_TX_LAST_HALF) begin
                  n.tx_st   = ir_codec_pkg::TX_GAP;
                  n.tx_half = '0;
               end else begin
                  n.tx_half = s_q.tx_half + 5'h1;
                  if (s_q.tx_half[0]) begin
                     n.tx_frame = {s_q.tx_frame[12:0], 1'b0};
                  end
               end
            end else begin
               n.tx_timer = s_q.tx_timer + 16'h1;
            end
         end
         ir_codec_pkg::TX_GAP: begin
            // Idle gap keeps the sustained rate under the line budget
            if (s_q.tx_timer == 16'(HALF_BIT_CYCLES - 1)) begin
               n.tx_timer = '0;
               n.tx_half  = s_q.tx_half + 5'h1;
               if (s_q.tx_half == 5'(GAP_HALVES - 1)) begin
                  n.tx_st = ir_codec_pkg::TX_IDLE;
               end
            end else begin
               n.tx_timer = s_q.tx_timer + 16'h1;
            end
         end
         default: n.tx_st = ir_codec_pkg::TX_IDLE;
      endcase
      // Zero is mark then space, one is space then mark
      n.tx_mark = n.tx_st == ir_codec_pkg::TX_SEND && n.tx_half[0] == n.tx_frame[13];
      if (!n.tx_mark) begin
         n.car_cnt = '0;
         n.car     = 1'b1;
      end else if (s_q.car_cnt >= s_q.carrier_rate_setting - 12'h1) begin
         n.car_cnt = '0;
         n.car     = !s_q.car;
      end else begin
         n.car_cnt = s_q.car_cnt + 12'h1;
      end
      n.tx_line = n.car & n.tx_mark;
      n.tx_pins = '0;
      n.tx_pins[{n.transmit_port_select, n.transmit_bit_index}] = n.tx_line;

      // ----------------------------------------------------------------------
      // AXI4-Lite write channel
      // ----------------------------------------------------------------------
      if (s_q.awready && awvalid) begin
         n.aw_got  = 1'b1;
         n.aw_addr = awaddr;
      end
      if (s_q.wready && wvalid) begin
         n.w_got  = 1'b1;
         n.w_data = wdata;
         n.w_strb = wstrb;
      end
      wr_ok = s_q.aw_got && s_q.w_got && !s_q.bvalid
              && (s_q.aw_addr != `IR_OFF_SEND_WORD || buf_in_ready);
      if (wr_ok) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = `IR_RESP_OKAY;
         case (s_q.aw_addr)
            `IR_OFF_SEND_WORD: ;
            `IR_OFF_RECEIVED_WORD: begin
               merged          = ({16'h0, s_q.received_word} & ~wmask) | (s_q.w_data & wmask);
               n.received_word = merged[15:0];
            end
            `IR_OFF_CONFIG: begin
               merged                 = (cfg_img & ~wmask) | (s_q.w_data & wmask);
               n.carrier_rate_setting = merged[`IR_CFG_RATE_LSB +: 12];
               n.receive_bit_index    = merged[`IR_CFG_RX_BIT_LSB +: 3];
               n.receive_port_select  = merged[`IR_CFG_RX_PORT_LSB +: 2];
               n.transmit_bit_index   = merged[`IR_CFG_TX_BIT_LSB +: 3];
               n.transmit_port_select = merged[`IR_CFG_TX_PORT_LSB +: 2];
            end
            `IR_OFF_STATUS: begin
               if (s_q.w_strb[0] && s_q.w_data[`IR_ST_RX_NEW]) begin
                  n.rx_new = 1'b0;
               end
            end
            default: n.bresp = `IR_RESP_SLVERR;
         endcase
      end
      if (s_q.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      n.awready = !n.aw_got;
      n.wready  = !n.w_got;

      // Hardware load after the software write so a new word wins
      if (rx_done_c) begin
         n.received_word = word_c;
         n.rx_new        = 1'b1;
      end

      // ----------------------------------------------------------------------
      // AXI4-Lite read channel
      // ----------------------------------------------------------------------
      if (s_q.arready && arvalid) begin
         n.arready = 1'b0;
         n.rresp   = `IR_RESP_OKAY;
         case (araddr)
            `IR_OFF_BLOCKING_RECEIVE: n.rd_wait = 1'b1;
            `IR_OFF_SEND_WORD: begin
               n.rvalid = 1'b1;
               n.rdata  = '0;
            end
            `IR_OFF_RECEIVED_WORD: begin
               n.rvalid = 1'b1;
               n.rdata  = {16'h0, s_q.received_word};
            end
            `IR_OFF_CONFIG: begin
               n.rvalid = 1'b1;
               n.rdata  = cfg_img;
            end
            `IR_OFF_STATUS: begin
               n.rvalid = 1'b1;
               n.rdata  = st_img;
            end
            default: begin
               n.rvalid = 1'b1;
               n.rdata  = '0;
               n.rresp  = `IR_RESP_SLVERR;
            end
         endcase
      end
      // Blocking read holds rvalid off until the next word completes
      if (s_q.rd_wait && rx_done_c) begin
         n.rd_wait = 1'b0;
         n.rvalid  = 1'b1;
         n.rdata   = {16'h0, word_c};
      end
      if (s_q.rvalid && rready) begin
         n.rvalid  = 1'b0;
         n.arready = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= RST;
      end else begin
         s_q <= n;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_tx_start;
      s_q.tx_st == ir_codec_pkg::TX_IDLE && buf_out_valid;
   endsequence
   sequence s_frame_end;
      s_q.tx_st == ir_codec_pkg::TX_SEND && s_q.tx_half == `IR_TX_LAST_HALF
         && s_q.tx_timer == 16'(HALF_BIT_CYCLES - 1);
   endsequence

   property p_lead_ones;
      @(posedge aclk) disable iff (!aresetn)
      s_tx_start |=> s_q.tx_st == ir_codec_pkg::TX_SEND && s_q.tx_frame[13:12] == 2'b11;
   endproperty
   a_lead_ones: assert property (p_lead_ones) else $error("frame lacks two leading ones");

   property p_field_order;
      @(posedge aclk) disable iff (!aresetn)
      s_tx_start |=> s_q.tx_frame[11:0] == $past(buf_out_data) && s_q.tx_half == '0;
   endproperty
   a_field_order: assert property (p_field_order) else $error("word bits out of order");

   property p_half_len;
      @(posedge aclk) disable iff (!aresetn)
      s_q.tx_st == ir_codec_pkg::TX_SEND && $past(s_q.tx_st) == ir_codec_pkg::TX_SEND
         && $changed(s_q.tx_half) |-> $past(s_q.tx_timer) == 16'(HALF_BIT_CYCLES - 1);
   endproperty
   a_half_len: assert property (p_half_len) else $error("half-bit length wrong");

   property p_space_dark;
      @(posedge aclk) disable iff (!aresetn)
      !s_q.tx_mark |-> tx_pins == '0;
   endproperty
   a_space_dark: assert property (p_space_dark) else $error("LED lit during space");

   property p_led_on;
      @(posedge aclk) disable iff (!aresetn)
      s_q.tx_line |-> tx_pins[{s_q.transmit_port_select, s_q.transmit_bit_index}];
   endproperty
   a_led_on: assert property (p_led_on) else $error("LED pin not high for carrier");

   property p_gap;
      @(posedge aclk) disable iff (!aresetn)
      s_frame_end |=> (s_q.tx_st == ir_codec_pkg::TX_GAP && tx_pins == '0) [*4];
   endproperty
   a_gap: assert property (p_gap) else $error("no idle gap after frame");

   property p_rx_start;
      @(posedge aclk) disable iff (!aresetn)
      s_q.rx_st == ir_codec_pkg::RX_IDLE && s_q.rx_prev && !lvl
         |=> s_q.rx_st == ir_codec_pkg::RX_RUN && s_q.rx_idx == '0;
   endproperty
   a_rx_start: assert property (p_rx_start) else $error("falling edge did not start");

   property p_bad_word;
      @(posedge aclk) disable iff (!aresetn)
      rx_done_c && rx_bad_c |=> s_q.received_word == `IR_INVALID_WORD && s_q.rx_new;
   endproperty
   a_bad_word: assert property (p_bad_word) else $error("bad word not flagged all ones");

   property p_rx_store;
      @(posedge aclk) disable iff (!aresetn)
      rx_done_c && !rx_bad_c |=> s_q.received_word == {4'h0, $past(n.rx_bits[11:0])};
   endproperty
   a_rx_store: assert property (p_rx_store) else $error("good word not stored");

   property p_block;
      @(posedge aclk) disable iff (!aresetn)
      s_q.rd_wait && rx_done_c |=> rvalid && rdata[15:0] == s_q.received_word;
   endproperty
   a_block: assert property (p_block) else $error("blocking read missed word");

endmodule

// ### sim/ir_line_model.sv
`timescale 1ns/1ps
module ir_line_model #(
   parameter int H = 40
) (
   input  wire logic aclk,
   input  wire logic led,
   output logic      rx_line
);
   // ----------------------------------------
   // Receiver module output and LED watcher
   // ----------------------------------------
   logic [13:0] seen_q [$];
   logic [13:0] f;
   logic        m;

   initial rx_line = 1'b1;

   // Only bi-phase patterns; a bad word is made by a bad first bit
   task automatic send(input logic [13:0] w);
      for (int i = 13; i >= 0; i--) begin
         rx_line <= w[i];
         repeat (H) @(posedge aclk);
         rx_line <= ~w[i];
         repeat (H) @(posedge aclk);
      end
      rx_line <= 1'b1;
   endtask

   // First light is the second half of the leading one
   initial forever begin
      @(posedge aclk iff led);
      for (int i = 13; i >= 0; i--) begin
         m = 1'b0;
         repeat (H) begin
            m = m | led;
            @(posedge aclk);
         end
         f[i] = m;
         repeat (H) @(posedge aclk);
      end
      seen_q.push_back(f);
   end
endmodule

// ### sim/ir_remote_word_codec_test.sv
`timescale 1ns/1ps
`include "ir_codec_params.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
   $display("unexpected %0t: %h not %h", $time, a, b); end end
module ir_remote_word_codec_test;
   // ----------------------------------------
   // Bench
   // ----------------------------------------
   localparam logic [31:0] CFG = 32'h01020003;
   logic        aclk = 1'b0, aresetn = 1'b0, rx_line;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, tx_pins;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid;
   int          failures = 0, cmp_count = 0, cyc = 0;
   // Model sits on pin 2; the other inputs idle high
   wire  [31:0] rx_pins = {29'h1fffffff, rx_line, 2'h3};

   ir_remote_word_codec #(.HALF_BIT_CYCLES(40), .GAP_HALVES(4)) dut_u (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .rx_pins, .tx_pins);
   ir_line_model #(.H(40)) line_u (.aclk, .led(tx_pins[1]), .rx_line);

   initial forever #20 aclk = ~aclk;

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      fork
         begin
            @(posedge aclk iff awready);
            awvalid <= 1'b0;
         end
         begin
            @(posedge aclk iff wready);
            wvalid <= 1'b0;
         end
      join
      @(posedge aclk iff bvalid);
      bready <= 1'b0;
      `CHK(bresp, e)
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(posedge aclk iff arready);
      arvalid <= 1'b0;
      @(posedge aclk iff rvalid);
      rready <= 1'b0;
      `CHK(rdata, x)
      `CHK(rresp, e)
      @(posedge aclk);
   endtask

   task automatic t_regs;
      rd(`IR_OFF_RECEIVED_WORD, 32'h0000ffff, `IR_RESP_OKAY);
      rd(`IR_OFF_CONFIG, 32'h0000015b, `IR_RESP_OKAY);
      rd(8'h14, 32'h0, `IR_RESP_SLVERR);
      rd(`IR_OFF_STATUS, 32'h0, `IR_RESP_OKAY);
      rd(`IR_OFF_SEND_WORD, 32'h0, `IR_RESP_OKAY);
      wr(`IR_OFF_BLOCKING_RECEIVE, 32'h0, `IR_RESP_SLVERR);
      wr(`IR_OFF_CONFIG, CFG, `IR_RESP_OKAY);
      rd(`IR_OFF_CONFIG, CFG, `IR_RESP_OKAY);
   endtask

   // Fourth word must wait for buffer room behind the busy sender
   task automatic t_tx;
      logic [11:0] w [4] = '{12'ha5c, 12'h3f1, 12'h000, 12'hfff};
      for (int i = 0; i < 4; i++) wr(`IR_OFF_SEND_WORD, {20'h0, w[i]}, `IR_RESP_OKAY);
      while (line_u.seen_q.size() < 4) @(posedge aclk);
      for (int i = 0; i < 4; i++) `CHK(line_u.seen_q[i], {2'b11, w[i]})
      `CHK(tx_pins, 32'h0)
   endtask

   task automatic t_rx;
      wr(`IR_OFF_RECEIVED_WORD, 32'h0000ffff, `IR_RESP_OKAY);
      line_u.send({2'b11, 12'h5a3});
      rd(`IR_OFF_RECEIVED_WORD, 32'h000005a3, `IR_RESP_OKAY);
      rd(`IR_OFF_STATUS, 32'h00000004, `IR_RESP_OKAY);
      wr(`IR_OFF_STATUS, 32'h00000004, `IR_RESP_OKAY);
      rd(`IR_OFF_STATUS, 32'h0, `IR_RESP_OKAY);
      // Check bit flipped, as for a new key press
      fork
         rd(`IR_OFF_BLOCKING_RECEIVE, 32'h00000ac7, `IR_RESP_OKAY);
         line_u.send({2'b11, 12'hac7});
      join
      rd(`IR_OFF_RECEIVED_WORD, 32'h00000ac7, `IR_RESP_OKAY);
      line_u.send(14'h1fff);
      rd(`IR_OFF_RECEIVED_WORD, 32'h0000ffff, `IR_RESP_OKAY);
   endtask

   task automatic end_sim;
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         end_sim;
      end
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_tx;
      t_rx;
      end_sim;
   end
endmodule
